// File: rtl/bcpr_pkg.sv
// Constants and carrier types for the boot config and pin routing block.
// Assumes a 125 MHz CPU clock and a 16-bit I/O port bus.
package bcpr_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [15:0] ROUTE_ADDR = 16'h1C00;
  localparam logic [15:0] ROUTE_RESET = 16'h0000;
  localparam logic [15:0] ROUTE_WMASK = 16'h7F3F;
  localparam int PP_SEL_LSB = 12;
  localparam int SP1_SEL_LSB = 10;
  localparam int SP0_SEL_LSB = 8;
  localparam int ADDR_SEL_LSB = 0;
  // ----------------------------------------
  // Pin counts and codes
  // ----------------------------------------
  localparam int PP_PINS = 21;
  localparam int SP_PINS = 6;
  localparam int SP_PORTS = 2;
  localparam int ADDR_PINS = 6;
  localparam logic [2:0] PP_RESERVED = 3'h7;
  localparam logic [1:0] SP_RESERVED = 2'h3;
  localparam int SP_AUD_PINS = 4;
  localparam int PERIPH_N = 8;
  localparam int IDLE_N = 8;
  localparam int IDLE_CPU_BIT = 0;
  // ----------------------------------------
  // Boot clock and settle timing
  // ----------------------------------------
  localparam logic [10:0] PLL_MULT_OSC = 11'h177;
  localparam logic [10:0] PLL_MULT_BYPASS = 11'h000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SETTLE_MS = 200;
  localparam int SETTLE_CYC = (SETTLE_MS * 1000000) / CLK_PERIOD_NS;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    OWN_NONE, OWN_SPI, OWN_UART, OWN_AUD2, OWN_AUD3, OWN_GPIO, OWN_CARD, OWN_AUD
  } bcpr_owner_type;
  typedef enum logic [1:0] {TGT_OTHER, TGT_FIRST_GENERAL_TIMER, TGT_CLKGEN} bcpr_target_type;
  typedef struct packed {
    logic [PP_PINS-1:0] dout;
    logic [PP_PINS-1:0] oe_b;
  } bcpr_pp_drive_type;
  typedef struct packed {
    logic [SP_PINS-1:0] dout;
    logic [SP_PINS-1:0] oe_b;
  } bcpr_sp_drive_type;
  typedef struct packed {
    logic [ADDR_PINS-1:0] dout;
    logic [ADDR_PINS-1:0] oe_b;
  } bcpr_addr_drive_type;
endpackage

// File: rtl/bcpr_top.sv
// Boot strap capture, boot clock settings and pin routing register.
// Assumes straps are static, the I/O bus is synchronous to ref_clk,
// and peripherals present drive structs aligned to pin positions.
//
// How it works
// - Routing register sits at port address 0x1C00.
// - A write to the register changes pin routing on the next cycle.
// - Bits 14:12 pick the parallel-port mix over its 21 pins.
// - Bits 11:10 and 9:8 pick each serial port's pin owners.
// - Bits 5:0 switch each upper address pin to GPIO individually.
// - Mode bit set: that address pin acts as a GPIO.
// - Mode bit clear: the memory interface drives that address pin.
// - Fields reset to zero; bits 15, 7, 6 read as zero.
// - Clock strap low: oscillator feeds RTC and clock generator, EXTERNAL_CLOCK_INPUT ignored.
// - Clock strap high: EXTERNAL_CLOCK_INPUT feeds clock generator, oscillator only RTC.
// - Clock strap low: boot sets generator to oscillator times 375.
// - Clock strap high: boot bypasses the clock generator.
// - Boot waits 200 ms settle; boot writes never touch first_general_timer or clocks.
// - Peripheral clocks on only during query; at hand-off all off, non-CPU idle.
// - Regulator strap low: power-on monitor drives internal power good.
// - Regulator strap high: power good forced high, reset from pin only.
// - Parallel codes 0 to 6 select modes, code 7 reserved.
// - Serial port 1: 01 audio plus two GPIO, 10 six GPIO, 11 reserved.
// - Serial port 0: 00 card, 01 audio plus two GPIO, 10 GPIO, 11 reserved.
// - Bit 15 is read-only; writes do nothing.
`timescale 1ns/100ps
module bcpr_top #(
  parameter int SETTLE_COUNT = bcpr_pkg::SETTLE_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_wdata,
  output logic [15:0] io_rdata,
  output logic io_rvalid,
  input wire logic clk_sel_strap,
  input wire logic regulator_enable_strap,
  input wire logic por_monitor_ok,
  output logic strap_captured,
  output logic sysclk_from_ext,
  output logic external_clock_input_en,
  output logic rtc_from_osc,
  output logic pll_bypass,
  output logic [10:0] pll_mult,
  output logic power_good_internal,
  output logic volt_monitor_en,
  output logic reset_from_pin_only,
  output logic settle_done,
  input wire logic boot_cfg_wr,
  input wire bcpr_pkg::bcpr_target_type boot_cfg_target,
  output logic boot_cfg_wr_allow,
  input wire logic [bcpr_pkg::PERIPH_N-1:0] boot_query,
  input wire logic boot_handoff,
  output logic [bcpr_pkg::PERIPH_N-1:0] periph_clk_en,
  output logic [bcpr_pkg::IDLE_N-1:0] idle_domain_control,
  input wire bcpr_pkg::bcpr_pp_drive_type spi_pp_drv,
  input wire bcpr_pkg::bcpr_pp_drive_type uart_pp_drv,
  input wire bcpr_pkg::bcpr_pp_drive_type aud2_pp_drv,
  input wire bcpr_pkg::bcpr_pp_drive_type aud3_pp_drv,
  input wire bcpr_pkg::bcpr_pp_drive_type gpio_pp_drv,
  input wire logic [bcpr_pkg::PP_PINS-1:0] pp_pin_in,
  output logic [bcpr_pkg::PP_PINS-1:0] pp_pin_out,
  output logic [bcpr_pkg::PP_PINS-1:0] pp_pin_oe_b,
  output logic [bcpr_pkg::PP_PINS-1:0] spi_pp_in,
  output logic [bcpr_pkg::PP_PINS-1:0] uart_pp_in,
  output logic [bcpr_pkg::PP_PINS-1:0] aud2_pp_in,
  output logic [bcpr_pkg::PP_PINS-1:0] aud3_pp_in,
  output logic [bcpr_pkg::PP_PINS-1:0] gpio_pp_in,
  input wire bcpr_pkg::bcpr_sp_drive_type card_sp_drv [bcpr_pkg::SP_PORTS],
  input wire bcpr_pkg::bcpr_sp_drive_type aud_sp_drv [bcpr_pkg::SP_PORTS],
  input wire bcpr_pkg::bcpr_sp_drive_type gpio_sp_drv [bcpr_pkg::SP_PORTS],
  input wire logic [bcpr_pkg::SP_PINS-1:0] sp_pin_in [bcpr_pkg::SP_PORTS],
  output logic [bcpr_pkg::SP_PINS-1:0] sp_pin_out [bcpr_pkg::SP_PORTS],
  output logic [bcpr_pkg::SP_PINS-1:0] sp_pin_oe_b [bcpr_pkg::SP_PORTS],
  output logic [bcpr_pkg::SP_PINS-1:0] card_sp_in [bcpr_pkg::SP_PORTS],
  output logic [bcpr_pkg::SP_PINS-1:0] aud_sp_in [bcpr_pkg::SP_PORTS],
  output logic [bcpr_pkg::SP_PINS-1:0] gpio_sp_in [bcpr_pkg::SP_PORTS],
  input wire logic [bcpr_pkg::ADDR_PINS-1:0] emif_addr_out,
  input wire bcpr_pkg::bcpr_addr_drive_type gpio_addr_drv,
  input wire logic [bcpr_pkg::ADDR_PINS-1:0] addr_pin_in,
  output logic [bcpr_pkg::ADDR_PINS-1:0] ext_mem_addr_pins,
  output logic [bcpr_pkg::ADDR_PINS-1:0] addr_pin_oe_b,
  output logic [bcpr_pkg::ADDR_PINS-1:0] gpio_addr_in
);
  import bcpr_pkg::*;

  // ----------------------------------------
  // Routing register
  // ----------------------------------------
  logic [15:0] route_q;
  logic hit;
  logic [2:0] pp_sel;
  logic [1:0] sp_sel [SP_PORTS];
  logic [ADDR_PINS-1:0] addr_sel;

  assign hit = (io_addr == ROUTE_ADDR);
  assign pp_sel = route_q[PP_SEL_LSB+:3];
  assign sp_sel[0] = route_q[SP0_SEL_LSB+:2];
  assign sp_sel[1] = route_q[SP1_SEL_LSB+:2];
  assign addr_sel = route_q[ADDR_SEL_LSB+:ADDR_PINS];

  // Reserved bits never store, so readback of them is zero
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      route_q <= ROUTE_RESET;
    end else if (io_wr && hit) begin
      route_q <= io_wdata & ROUTE_WMASK;
    end
  end

  // Unmapped reads answer zero rather than hanging the bus
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      io_rdata <= 16'h0000;
      io_rvalid <= 1'b0;
    end else begin
      io_rvalid <= io_rd;
      io_rdata <= (io_rd && hit) ? route_q : 16'h0000;
    end
  end

  // ----------------------------------------
  // Strap capture
  // ----------------------------------------
  logic clk_sel_q;
  logic ldo_q;
  logic cap_q;

  // Straps are sampled once after release; a change needs a new reset
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cap_q <= 1'b0;
      clk_sel_q <= 1'b0;
      ldo_q <= 1'b0;
    end else if (!cap_q) begin
      cap_q <= 1'b1;
      clk_sel_q <= clk_sel_strap;
      ldo_q <= regulator_enable_strap;
    end
  end

  assign strap_captured = cap_q;
  assign sysclk_from_ext = clk_sel_q;
  assign external_clock_input_en = clk_sel_q;
  assign rtc_from_osc = 1'b1;
  assign pll_bypass = clk_sel_q;
  assign pll_mult = clk_sel_q ? PLL_MULT_BYPASS : PLL_MULT_OSC;
  assign power_good_internal = ldo_q | por_monitor_ok;
  assign volt_monitor_en = ~ldo_q;
  assign reset_from_pin_only = ldo_q;

  // ----------------------------------------
  // Boot settle and clock housekeeping
  // ----------------------------------------
  logic [24:0] settle_q;
  logic handoff_q;
  logic [PERIPH_N-1:0] pclk_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      settle_q <= 25'h000_0000;
    end else if (settle_q != 25'(SETTLE_COUNT)) begin
      settle_q <= settle_q + 25'h000_0001;
    end
  end
  assign settle_done = (settle_q == 25'(SETTLE_COUNT));

  // First_general_timer and clock generator stay out of reach of boot image writes
  assign boot_cfg_wr_allow = boot_cfg_wr && (boot_cfg_target == TGT_OTHER);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      handoff_q <= 1'b0;
    end else if (boot_handoff) begin
      handoff_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pclk_q <= '0;
    end else begin
      pclk_q <= (handoff_q || boot_handoff) ? '0 : boot_query;
    end
  end
  assign periph_clk_en = pclk_q;
  always_comb begin
    idle_domain_control = handoff_q ? '1 : '0;
    idle_domain_control[IDLE_CPU_BIT] = 1'b0;
  end

  // ----------------------------------------
  // Owner tables
  // ----------------------------------------
  function automatic bcpr_owner_type pp_owner(input logic [2:0] m, input int p);
    bcpr_owner_type o;
    o = OWN_NONE;
    case (m)
      3'h0: o = OWN_NONE;
      3'h1: o = (p < 7) ? OWN_SPI : (p < 13) ? OWN_GPIO : (p < 17) ? OWN_UART : OWN_AUD2;
      3'h2: o = (p < 8) ? OWN_GPIO : OWN_NONE;
      3'h3: o = (p < 4) ? OWN_SPI : (p < 8) ? OWN_AUD3 : OWN_NONE;
      3'h4: o = (p < 4) ? OWN_AUD2 : (p < 8) ? OWN_UART : OWN_NONE;
      3'h5: o = (p < 4) ? OWN_SPI : (p < 8) ? OWN_UART : OWN_NONE;
      3'h6: o = (p < 7) ? OWN_SPI : (p < 11) ? OWN_AUD2 : (p < 15) ? OWN_AUD3 : OWN_GPIO;
      default: o = OWN_NONE;
    endcase
    return o;
  endfunction

  function automatic bcpr_owner_type sp_owner(input logic [1:0] m, input int p);
    bcpr_owner_type o;
    o = OWN_NONE;
    case (m)
      2'h0: o = OWN_CARD;
      2'h1: o = (p < SP_AUD_PINS) ? OWN_AUD : OWN_GPIO;
      2'h2: o = OWN_GPIO;
      default: o = OWN_NONE;
    endcase
    return o;
  endfunction

  // ----------------------------------------
  // Parallel port muxing
  // ----------------------------------------
  // Muxing is combinational on the register so a write lands next cycle
  for (genvar i = 0; i < PP_PINS; i++) begin : g_pp
    bcpr_owner_type own;
    assign own = pp_owner(pp_sel, i);
    always_comb begin
      pp_pin_out[i] = 1'b0;
      pp_pin_oe_b[i] = 1'b1;
      case (own)
        OWN_SPI: begin
          pp_pin_out[i] = spi_pp_drv.dout[i];
          pp_pin_oe_b[i] = spi_pp_drv.oe_b[i];
        end
        OWN_UART: begin
          pp_pin_out[i] = uart_pp_drv.dout[i];
          pp_pin_oe_b[i] = uart_pp_drv.oe_b[i];
        end
        OWN_AUD2: begin
          pp_pin_out[i] = aud2_pp_drv.dout[i];
          pp_pin_oe_b[i] = aud2_pp_drv.oe_b[i];
        end
        OWN_AUD3: begin
          pp_pin_out[i] = aud3_pp_drv.dout[i];
          pp_pin_oe_b[i] = aud3_pp_drv.oe_b[i];
        end
        OWN_GPIO: begin
          pp_pin_out[i] = gpio_pp_drv.dout[i];
          pp_pin_oe_b[i] = gpio_pp_drv.oe_b[i];
        end
        default: begin
          pp_pin_out[i] = 1'b0;
          pp_pin_oe_b[i] = 1'b1;
        end
      endcase
    end
    assign spi_pp_in[i] = pp_pin_in[i] & (own == OWN_SPI);
    assign uart_pp_in[i] = pp_pin_in[i] & (own == OWN_UART);
    assign aud2_pp_in[i] = pp_pin_in[i] & (own == OWN_AUD2);
    assign aud3_pp_in[i] = pp_pin_in[i] & (own == OWN_AUD3);
    assign gpio_pp_in[i] = pp_pin_in[i] & (own == OWN_GPIO);
  end

  // ----------------------------------------
  // Serial port muxing
  // ----------------------------------------
  for (genvar j = 0; j < SP_PORTS; j++) begin : g_sp
    for (genvar i = 0; i < SP_PINS; i++) begin : g_pin
      bcpr_owner_type own;
      assign own = sp_owner(sp_sel[j], i);
      always_comb begin
        sp_pin_out[j][i] = 1'b0;
        sp_pin_oe_b[j][i] = 1'b1;
        case (own)
          OWN_CARD: begin
            sp_pin_out[j][i] = card_sp_drv[j].dout[i];
            sp_pin_oe_b[j][i] = card_sp_drv[j].oe_b[i];
          end
          OWN_AUD: begin
            sp_pin_out[j][i] = aud_sp_drv[j].dout[i];
            sp_pin_oe_b[j][i] = aud_sp_drv[j].oe_b[i];
          end
          OWN_GPIO: begin
            sp_pin_out[j][i] = gpio_sp_drv[j].dout[i];
            sp_pin_oe_b[j][i] = gpio_sp_drv[j].oe_b[i];
          end
          default: begin
            sp_pin_out[j][i] = 1'b0;
            sp_pin_oe_b[j][i] = 1'b1;
          end
        endcase
      end
      assign card_sp_in[j][i] = sp_pin_in[j][i] & (own == OWN_CARD);
      assign aud_sp_in[j][i] = sp_pin_in[j][i] & (own == OWN_AUD);
      assign gpio_sp_in[j][i] = sp_pin_in[j][i] & (own == OWN_GPIO);
    end
  end

  // ----------------------------------------
  // Upper address pins
  // ----------------------------------------
  for (genvar i = 0; i < ADDR_PINS; i++) begin : g_addr
    // Memory interface drives its address outputs only while the pin's mode bit is clear; set, GPIO drives the pin
    assign ext_mem_addr_pins[i] = addr_sel[i] ? gpio_addr_drv.dout[i] : emif_addr_out[i];
    assign addr_pin_oe_b[i] = addr_sel[i] ? gpio_addr_drv.oe_b[i] : 1'b0;
    assign gpio_addr_in[i] = addr_pin_in[i] & addr_sel[i];
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_WRITE_NEXT: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (io_wr && io_addr == ROUTE_ADDR) |=> route_q == ($past(io_wdata) & ROUTE_WMASK))
    else $error("routing write not applied next cycle");
  AST_READ_ZERO: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    io_rvalid |-> (io_rdata[15] == 1'b0 && io_rdata[7:6] == 2'b00))
    else $error("reserved routing bits read nonzero");
  AST_READBACK: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (io_rd && io_addr == ROUTE_ADDR && !io_wr) |=> io_rvalid && io_rdata == $past(route_q))
    else $error("routing readback mismatch");
  AST_PP_RESERVED: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (pp_sel == PP_RESERVED) |-> (&pp_pin_oe_b && gpio_pp_in == '0 && spi_pp_in == '0))
    else $error("reserved parallel code drives pins");
  AST_SP_RESERVED: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (sp_sel[1] == SP_RESERVED) |-> &sp_pin_oe_b[1])
    else $error("reserved serial code drives pins");
  AST_SP0_CARD: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (sp_sel[0] == 2'h0) |-> sp_pin_oe_b[0] == card_sp_drv[0].oe_b)
    else $error("serial port 0 mode 0 not card");
  AST_ADDR_EMIF: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (!addr_sel[0]) |-> (!addr_pin_oe_b[0] && ext_mem_addr_pins[0] == emif_addr_out[0]))
    else $error("address pin lost memory interface");
  AST_ADDR_GPIO: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (io_wr && io_addr == ROUTE_ADDR && io_wdata[5]) |=> gpio_addr_in[5] == addr_pin_in[5])
    else $error("address pin not switched to GPIO");
  AST_POWER_GOOD: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (cap_q && ldo_q) |-> (power_good_internal && !volt_monitor_en))
    else $error("regulator strap high but power good not forced");
  AST_CLK_SRC: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    $rose(cap_q) && !$past(clk_sel_strap) |-> (pll_mult == PLL_MULT_OSC && !pll_bypass))
    else $error("oscillator boot multiplier wrong");
  AST_HANDOFF: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    boot_handoff |=> (periph_clk_en == '0 && idle_domain_control == {{(IDLE_N-1){1'b1}}, 1'b0}))
    else $error("clocks left on after hand-off");
endmodule

// File: verif/bcpr_env_model.sv
// Far-side model: peripheral drives, pad inputs and memory address drive.
// Assumes the bench pulses shuffle for one cycle to draw new values.
`timescale 1ns/100ps
module bcpr_env_model (
  input wire logic ref_clk,
  input wire logic shuffle,
  output bcpr_pkg::bcpr_pp_drive_type pp_drv [5],
  output logic [bcpr_pkg::PP_PINS-1:0] pp_pin_in,
  output bcpr_pkg::bcpr_sp_drive_type sp_drv [3][bcpr_pkg::SP_PORTS],
  output logic [bcpr_pkg::SP_PINS-1:0] sp_pin_in [bcpr_pkg::SP_PORTS],
  output logic [bcpr_pkg::ADDR_PINS-1:0] emif_addr_out,
  output bcpr_pkg::bcpr_addr_drive_type gpio_addr_drv,
  output logic [bcpr_pkg::ADDR_PINS-1:0] addr_pin_in
);
  import bcpr_pkg::*;
  int seed = 87668;
  // Fresh state per draw, as after a peripheral reset
  task automatic load();
    for (int k = 0; k < 5; k++) pp_drv[k] = 42'({$random(seed), $random(seed)});
    pp_pin_in = 21'($random(seed));
    for (int p = 0; p < SP_PORTS; p++) begin
      for (int k = 0; k < 3; k++) sp_drv[k][p] = 12'($random(seed));
      sp_pin_in[p] = 6'($random(seed));
    end
    emif_addr_out = 6'($random(seed));
    gpio_addr_drv = 12'($random(seed));
    addr_pin_in = 6'($random(seed));
  endtask
  initial load();
  // New draw lands on the falling edge, like all other stimulus
  always @(posedge ref_clk) begin
    if (shuffle) begin
      @(negedge ref_clk);
      load();
    end
  end
endmodule

// File: verif/boot_config_pin_routing_tb_top.sv
// Self-checking bench for the boot config and pin routing block.
// Assumes bcpr_pkg, bcpr_top and bcpr_env_model are compiled first.
`timescale 1ns/100ps
module boot_config_pin_routing_tb_top;
  import bcpr_pkg::*;
  localparam int SETTLE = 20;
  typedef struct {int sel; logic [127:0] exp;} bcpr_note_type;
  bcpr_note_type notes[$];
  bcpr_note_type cur;
  int num_errors = 0, cmp_count = 0, cycles = 0;
  logic ref_clk = 0, rst_b = 0, io_wr = 0, io_rd = 0, chk_req = 0, shuffle = 0;
  logic [15:0] io_addr = 16'h0000, io_wdata = 16'h0000, io_rdata;
  logic clk_sel_strap = 0, regulator_enable_strap = 0, por_monitor_ok = 1;
  logic boot_cfg_wr = 0, boot_handoff = 0, io_rvalid, strap_captured, sysclk_from_ext;
  logic external_clock_input_en, rtc_from_osc, pll_bypass, power_good_internal;
  logic volt_monitor_en, reset_from_pin_only, settle_done, boot_cfg_wr_allow;
  logic [10:0] pll_mult;
  logic [7:0] boot_query = 8'h00, periph_clk_en, idle_domain_control;
  bcpr_target_type boot_cfg_target = TGT_OTHER;
  bcpr_pp_drive_type pp_drv [5];
  logic [20:0] pp_pin_in, pp_pin_out, pp_pin_oe_b, spi_pp_in, uart_pp_in, aud2_pp_in;
  logic [20:0] aud3_pp_in, gpio_pp_in;
  bcpr_sp_drive_type sp_drv [3][SP_PORTS];
  logic [5:0] sp_pin_in [2], sp_pin_out [2], sp_pin_oe_b [2], card_sp_in [2];
  logic [5:0] aud_sp_in [2], gpio_sp_in [2];
  logic [5:0] emif_addr_out, addr_pin_in, ext_mem_addr_pins, addr_pin_oe_b, gpio_addr_in;
  bcpr_addr_drive_type gpio_addr_drv;

  bcpr_top #(.SETTLE_COUNT(SETTLE)) uut (.ref_clk, .rst_b, .io_addr, .io_wr, .io_rd,
    .io_wdata, .io_rdata, .io_rvalid, .clk_sel_strap, .regulator_enable_strap,
    .por_monitor_ok, .strap_captured, .sysclk_from_ext, .external_clock_input_en,
    .rtc_from_osc, .pll_bypass, .pll_mult, .power_good_internal, .volt_monitor_en,
    .reset_from_pin_only, .settle_done, .boot_cfg_wr, .boot_cfg_target, .boot_cfg_wr_allow,
    .boot_query, .boot_handoff, .periph_clk_en, .idle_domain_control,
    .spi_pp_drv(pp_drv[0]), .uart_pp_drv(pp_drv[1]), .aud2_pp_drv(pp_drv[2]),
    .aud3_pp_drv(pp_drv[3]), .gpio_pp_drv(pp_drv[4]), .pp_pin_in, .pp_pin_out,
    .pp_pin_oe_b, .spi_pp_in, .uart_pp_in, .aud2_pp_in, .aud3_pp_in, .gpio_pp_in,
    .card_sp_drv(sp_drv[0]), .aud_sp_drv(sp_drv[1]), .gpio_sp_drv(sp_drv[2]),
    .sp_pin_in, .sp_pin_out, .sp_pin_oe_b, .card_sp_in, .aud_sp_in, .gpio_sp_in,
    .emif_addr_out, .gpio_addr_drv, .addr_pin_in, .ext_mem_addr_pins, .addr_pin_oe_b,
    .gpio_addr_in);
  bcpr_env_model env (.ref_clk, .shuffle, .pp_drv, .pp_pin_in, .sp_drv, .sp_pin_in,
    .emif_addr_out, .gpio_addr_drv, .addr_pin_in);

  always #4 ref_clk = ~ref_clk;

  // ----------------------------
  // Monitor and closing
  // ----------------------------
  function automatic logic [127:0] act(int sel);
    case (sel)
      0: return 128'(io_rdata);
      1: return 128'({pp_pin_oe_b, pp_pin_out, spi_pp_in, gpio_pp_in});
      2, 3: return 128'({gpio_sp_in[sel-2], aud_sp_in[sel-2], card_sp_in[sel-2],
        sp_pin_oe_b[sel-2], sp_pin_out[sel-2]});
      4: return 128'({addr_pin_oe_b, ext_mem_addr_pins, gpio_addr_in});
      5: return 128'({strap_captured, sysclk_from_ext, external_clock_input_en, rtc_from_osc,
        pll_bypass, pll_mult, power_good_internal, volt_monitor_en, reset_from_pin_only});
      6: return 128'({settle_done, boot_cfg_wr_allow});
      8: return 128'({uart_pp_in, aud2_pp_in, aud3_pp_in});
      default: return 128'({periph_clk_en, idle_domain_control});
    endcase
  endfunction

  // Sampled on the rising edge, so inputs set at the falling edge have settled
  always @(posedge ref_clk) begin
    if (io_rvalid === 1'b1 || chk_req) begin
      if (notes.size() > 0) cur = notes.pop_front();
      else cur = '{-1, '0};
      cmp_count++;
      if (act(cur.sel) !== cur.exp) begin
        num_errors++;
        $display("[ERR] t=%0t sel %0d got %h exp %h", $time, cur.sel, act(cur.sel), cur.exp);
      end
    end
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 5000) begin
      num_errors++;
      close_out();
    end
  end

  // ----------------------------
  // Drivers and expectations
  // ----------------------------
  task automatic chk(int sel, logic [127:0] exp);
    notes.push_back('{sel, exp});
    chk_req = 1'b1;
    @(negedge ref_clk);
    chk_req = 1'b0;
    // Idle cycle so a following check never re-raises the strobe in one step
    @(negedge ref_clk);
  endtask

  task automatic rd(logic [15:0] a, logic [15:0] e);
    io_addr = a;
    io_rd = 1'b1;
    notes.push_back('{0, 128'(e)});
    @(negedge ref_clk);
    io_rd = 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic wr(logic [15:0] a, logic [15:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge ref_clk);
    io_wr = 1'b0;
  endtask

  task automatic shuf();
    shuffle = 1'b1;
    @(negedge ref_clk);
    shuffle = 1'b0;
  endtask

  task automatic do_reset(logic c, logic r, logic p);
    clk_sel_strap = c;
    regulator_enable_strap = r;
    por_monitor_ok = p;
    rst_b = 1'b0;
    repeat (16) @(negedge ref_clk);
    rst_b = 1'b1;
    @(negedge ref_clk);
  endtask

  // Owner per pin: 1 spi, 2 uart, 3 aud2, 4 aud3, 5 gpio, 0 none
  function automatic int pp_own(int m, int i);
    case (m)
      1: return i < 7 ? 1 : i < 13 ? 5 : i < 17 ? 2 : 3;
      2: return i < 8 ? 5 : 0;
      3: return i < 4 ? 1 : i < 8 ? 4 : 0;
      4: return i < 4 ? 3 : i < 8 ? 2 : 0;
      5: return i < 4 ? 1 : i < 8 ? 2 : 0;
      6: return i < 7 ? 1 : i < 11 ? 3 : i < 15 ? 4 : 5;
      default: return 0;
    endcase
  endfunction

  function automatic logic [127:0] pp_exp(int m, bit ins);
    logic [20:0] o, e, si, gi, ui, a2, a3;
    int w;
    o = '0;
    e = '1;
    si = '0;
    gi = '0;
    ui = '0;
    a2 = '0;
    a3 = '0;
    for (int i = 0; i < PP_PINS; i++) begin
      w = pp_own(m, i);
      if (w != 0) begin
        o[i] = pp_drv[w-1].dout[i];
        e[i] = pp_drv[w-1].oe_b[i];
      end
      if (w == 1) si[i] = pp_pin_in[i];
      if (w == 5) gi[i] = pp_pin_in[i];
      if (w == 2) ui[i] = pp_pin_in[i];
      if (w == 3) a2[i] = pp_pin_in[i];
      if (w == 4) a3[i] = pp_pin_in[i];
    end
    if (ins) return 128'({ui, a2, a3});
    return 128'({e, o, si, gi});
  endfunction

  function automatic logic [127:0] sp_exp(int p, int m);
    logic [5:0] o, e, ci, ai, gi;
    int w;
    o = '0;
    e = '1;
    ci = '0;
    ai = '0;
    gi = '0;
    for (int i = 0; i < SP_PINS; i++) begin
      w = m == 0 ? 0 : m == 1 ? (i < 4 ? 1 : 2) : m == 2 ? 2 : 3;
      if (w < 3) begin
        o[i] = sp_drv[w][p].dout[i];
        e[i] = sp_drv[w][p].oe_b[i];
      end
      if (w == 0) ci[i] = sp_pin_in[p][i];
      if (w == 1) ai[i] = sp_pin_in[p][i];
      if (w == 2) gi[i] = sp_pin_in[p][i];
    end
    return 128'({gi, ai, ci, e, o});
  endfunction

  function automatic logic [127:0] addr_exp(logic [5:0] s);
    logic [5:0] o, e, g;
    for (int i = 0; i < ADDR_PINS; i++) begin
      o[i] = s[i] ? gpio_addr_drv.dout[i] : emif_addr_out[i];
      e[i] = s[i] ? gpio_addr_drv.oe_b[i] : 1'b0;
      g[i] = s[i] ? addr_pin_in[i] : 1'b0;
    end
    return 128'({e, o, g});
  endfunction

  initial begin
    do_reset(1'b0, 1'b0, 1'b1);
    rd(ROUTE_ADDR, ROUTE_RESET);
    rd(16'h1C02, 16'h0000);
    boot_query = 8'h00;
    for (int m = 0; m < 8; m++) begin
      shuf();
      wr(ROUTE_ADDR, 16'(m << PP_SEL_LSB));
      chk(1, pp_exp(m, 1'b0));
      chk(8, pp_exp(m, 1'b1));
    end
    wr(ROUTE_ADDR, 16'hFFFF);
    rd(ROUTE_ADDR, 16'h7F3F);
    wr(16'h1C01, 16'h0000);
    rd(ROUTE_ADDR, 16'h7F3F);
    rd(16'h1C01, 16'h0000);
    $display("test parallel port done");
    for (int m = 0; m < 16; m++) begin
      shuf();
      wr(ROUTE_ADDR, 16'(m << SP0_SEL_LSB));
      chk(2, sp_exp(0, m % 4));
      chk(3, sp_exp(1, m / 4));
    end
    $display("test serial ports done");
    for (int k = 0; k < 64; k++) begin
      shuf();
      wr(ROUTE_ADDR, 16'(k));
      chk(4, addr_exp(6'(k)));
    end
    $display("test address pins done");
    for (int k = 0; k < 8; k++) begin
      do_reset(k[0], k[1], k[2]);
      chk(5, 128'({1'b1, k[0], k[0], 1'b1, k[0], k[0] ? 11'h000 : 11'h177,
        k[1] | k[2], ~k[1], k[1]}));
      rd(ROUTE_ADDR, 16'h0000);
    end
    $display("test straps done");
    // Settle end point: one cycle short still low, exact count high
    do_reset(1'b0, 1'b0, 1'b1);
    repeat (SETTLE - 2) @(negedge ref_clk);
    chk(6, 128'(2'b00));
    do_reset(1'b0, 1'b0, 1'b1);
    repeat (SETTLE - 1) @(negedge ref_clk);
    chk(6, 128'(2'b10));
    boot_cfg_wr = 1'b1;
    for (int t = 0; t < 3; t++) begin
      boot_cfg_target = bcpr_target_type'(t);
      chk(6, 128'({1'b1, t == 0}));
    end
    boot_cfg_wr = 1'b0;
    $display("test boot settle done");
    boot_query = 8'h5A;
    @(negedge ref_clk);
    chk(7, 128'({8'h5A, 8'h00}));
    boot_handoff = 1'b1;
    @(negedge ref_clk);
    boot_handoff = 1'b0;
    boot_query = 8'hFF;
    @(negedge ref_clk);
    chk(7, 128'({8'h00, 8'hFE}));
    $display("test peripheral clocks done");
    close_out();
  end
endmodule
